// [logic/fpus_pkg.sv]
// Shared constants for the flash page update sequencer
package fpus_pkg;
    // Register offsets on the special function register port
    localparam logic [7:0] FPUS_ADDR_CMD_STATUS = 8'he4;  // Status read, command write
    localparam logic [7:0] FPUS_ADDR_ADDR_LOW   = 8'he5;  // Slot index and page low bits
    localparam logic [7:0] FPUS_ADDR_ADDR_HIGH  = 8'he6;  // Page high bits
    localparam logic [7:0] FPUS_ADDR_WRITE_DATA = 8'he7;  // Page buffer load port

    // Command byte values
    localparam logic [7:0] FPUS_CMD_LOAD        = 8'h00;  // Clear buffer and flags
    localparam logic [7:0] FPUS_CMD_ERASE_PROG  = 8'h68;  // Erase then program page

    // Status bit positions
    localparam int FPUS_BIT_OI  = 0;                      // Operation interrupted
    localparam int FPUS_BIT_SV  = 1;                      // Security violation
    localparam int FPUS_BIT_HVE = 2;                      // High voltage error
    localparam int FPUS_BIT_HVA = 3;                      // High voltage abort
    localparam int FPUS_STATUS_BITS = 4;                  // Bits 7:4 read as zero

    // Values after reset
    localparam logic [7:0] FPUS_RESET_STATUS    = 8'h00;
    localparam logic [7:0] FPUS_RESET_ADDR      = 8'h00;

    // Geometry
    localparam int FPUS_PAGE_BYTES       = 64;            // Bytes per page
    localparam int FPUS_SLOT_BITS        = 6;             // Slot index width
    localparam int FPUS_SECTOR_BYTES     = 1024;          // Bytes per sector
    localparam int FPUS_PAGES_PER_SECTOR = FPUS_SECTOR_BYTES / FPUS_PAGE_BYTES;
    localparam int FPUS_PAGE_ADDR_BITS   = 10;            // High byte plus low bits 7:6
    localparam int FPUS_SECTOR_SHIFT     = 4;             // log2 of pages per sector

    // Timing: each phase lasts 2 ms, whole cycle 4 ms
    localparam longint FPUS_CLK_PERIOD_PS = 5000;         // 200 MHz
    localparam longint FPUS_PHASE_TIME_NS = 2000000;      // 2 ms
    localparam int FPUS_PHASE_CYCLES =
        int'((FPUS_PHASE_TIME_NS * 1000) / FPUS_CLK_PERIOD_PS);

    // Sequencer states
    typedef enum logic [1:0] {
        FPUS_IDLE,
        FPUS_ERASE,
        FPUS_PROGRAM
    } fpus_state_type;
endpackage : fpus_pkg

// [logic/fpus_page_buffer.sv]
// Page buffer storage with one-cycle clear and registered read
`timescale 1ns/1ps
module fpus_page_buffer
    import fpus_pkg::*;
#(
    parameter int DEPTH = FPUS_PAGE_BYTES,
    parameter int AW    = FPUS_SLOT_BITS
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          clear,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    // Depth must match the slot index width
    initial begin
        if (DEPTH != (1 << AW)) begin
            $error("fpus_page_buffer: DEPTH must equal 2**AW");
        end
    end

    logic [7:0] mem [DEPTH];  // Byte storage, flops so clear is one cycle

    // Storage; clear wins since a load command and a data write never coincide
    always_ff @(posedge clk) begin
        if (!resetn || clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : fpus_page_buffer

// [logic/fpus_phase_timer.sv]
// Fixed-length phase timer, pulses at the end of every phase
`timescale 1ns/1ps
module fpus_phase_timer
    import fpus_pkg::*;
#(
    parameter int PHASE_CYCLES = FPUS_PHASE_CYCLES
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic run,
    output logic      phase_done
);
    initial begin
        if (PHASE_CYCLES < 2) begin
            $error("fpus_phase_timer: PHASE_CYCLES too small");
        end
    end

    localparam logic [31:0] LAST = 32'(PHASE_CYCLES - 1);  // Final count of a phase

    logic [31:0] count;  // Cycles spent in current phase

    // Counter restarts on its own so back-to-back phases stay the same length
    always_ff @(posedge clk) begin
        if (!resetn || !run) begin
            count <= 32'h0000_0000;
        end else if (count == LAST) begin
            count <= 32'h0000_0000;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

    assign phase_done = run && (count == LAST);
endmodule : fpus_phase_timer

// [logic/fpus_sequencer.sv]
// Flash page update sequencer: registers, page buffer control, erase-program cycle
`timescale 1ns/1ps
module fpus_sequencer
    import fpus_pkg::*;
#(
    parameter int PHASE_CYCLES = FPUS_PHASE_CYCLES  // Cycles per 2 ms phase
) (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    // Special function register port, same clock as the processor
    input  wire logic [7:0]                     sfr_addr,
    input  wire logic                           sfr_wr,
    input  wire logic                           sfr_rd,
    input  wire logic [7:0]                     sfr_wdata,
    output logic      [7:0]                     sfr_rdata,
    // Processor side events, same clock
    input  wire logic                           irq_pending,
    input  wire logic                           warm_reset_req,
    input  wire logic                           page_secured,
    output logic                                cpu_stall,
    // Analog monitors, asynchronous
    input  wire logic                           flash_brownout_detect,
    input  wire logic                           hv_fault,
    // Flash array side
    output logic [FPUS_PAGE_ADDR_BITS-1:0]      check_page,
    output logic [FPUS_PAGE_ADDR_BITS-1:0]      flash_page_addr,
    output logic [FPUS_SLOT_BITS-1:0]           flash_byte_addr,
    output logic [7:0]                          flash_wdata,
    output logic                                flash_erase_strobe,
    output logic                                flash_prog_strobe
);
    // The walk over the buffer must fit inside one phase
    initial begin
        if (PHASE_CYCLES < 2 * FPUS_PAGE_BYTES) begin
            $error("fpus_sequencer: PHASE_CYCLES shorter than buffer walk");
        end
    end

    localparam int SB = FPUS_SLOT_BITS;
    localparam logic [SB:0] WALK_END = (SB+1)'(FPUS_PAGE_BYTES);  // Walk stop count

    fpus_state_type               state;            // Sequencer state
    fpus_state_type               next_state;       // Next sequencer state
    logic [7:0]                   flash_command_status;   // Status bits 3:0
    logic [7:0]                   flash_address_low;      // Slot index and page low bits
    logic [7:0]                   flash_address_high;     // Page high bits
    logic [FPUS_PAGE_BYTES-1:0]   update_flag;      // One flag per buffer byte
    logic [1:0]                   bod_sync;         // Brownout synchroniser
    logic [1:0]                   hvf_sync;         // Generator fault synchroniser
    logic                         brownout;         // Synchronised brownout level
    logic                         hv_err;           // Synchronised fault level
    logic [SB:0]                  walk_idx;         // Buffer walk position
    logic                         walk_valid;       // Buffer read issued last cycle
    logic [SB-1:0]                walk_slot;        // Slot of that read
    logic [7:0]                   buf_rdata;        // Registered buffer data
    logic                         phase_done;       // End of a 2 ms phase
    logic                         busy;             // Cycle under way
    logic                         cmd_wr;           // Command byte written
    logic                         data_wr;          // Write data register written
    logic                         load_cmd;         // Buffer clear command
    logic                         start_req;        // Erase-program requested
    logic                         go;               // Request passes the checks
    logic                         abort;            // Cycle ends early
    logic                         finish;           // Cycle ends normally

    // Two flops before any logic reads the analog monitors
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bod_sync <= 2'b00;
            hvf_sync <= 2'b00;
        end else begin
            bod_sync <= {bod_sync[0], flash_brownout_detect};
            hvf_sync <= {hvf_sync[0], hv_fault};
        end
    end
    assign brownout = bod_sync[1];
    assign hv_err   = hvf_sync[1];

    // Register decode; the processor is stalled while busy, so writes then are dropped
    assign busy      = (state != FPUS_IDLE);
    assign cmd_wr    = sfr_wr && !busy && (sfr_addr == FPUS_ADDR_CMD_STATUS);
    assign data_wr   = sfr_wr && !busy && (sfr_addr == FPUS_ADDR_WRITE_DATA);
    assign load_cmd  = cmd_wr && (sfr_wdata == FPUS_CMD_LOAD);
    assign start_req = cmd_wr && (sfr_wdata == FPUS_CMD_ERASE_PROG);
    // secured page or low supply refuses the start
    assign go        = start_req && !page_secured && !brownout;
    // any interrupt, reset request, brownout or fault ends the cycle
    assign abort     = busy && (irq_pending || warm_reset_req || brownout || hv_err);
    assign finish    = (state == FPUS_PROGRAM) && phase_done && !abort;

    // Next state: erase phase then program phase, each one timer period
    always_comb begin
        next_state = state;
        case (state)
            FPUS_IDLE: begin
                if (go) begin
                    next_state = FPUS_ERASE;
                end
            end
            FPUS_ERASE: begin
                if (abort) begin
                    next_state = FPUS_IDLE;
                end else if (phase_done) begin
                    next_state = FPUS_PROGRAM;
                end
            end
            FPUS_PROGRAM: begin
                if (abort || phase_done) begin
                    next_state = FPUS_IDLE;
                end
            end
            default: begin
                next_state = FPUS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= FPUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // fixed phase length, independent of flag count
    fpus_phase_timer #(
        .PHASE_CYCLES (PHASE_CYCLES)
    ) u_timer (
        .clk        (clk),
        .resetn     (resetn),
        .run        (busy && !abort),
        .phase_done (phase_done)
    );

    // stall held for exactly the busy states
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cpu_stall <= 1'b0;
        end else begin
            cpu_stall <= (next_state != FPUS_IDLE);
        end
    end

    // Status: a command write clears, but an event in the same cycle still sets
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_command_status <= FPUS_RESET_STATUS;
        end else begin
            if (cmd_wr) begin
                flash_command_status <= 8'h00;
            end
            // interrupt or reset request aborting a cycle
            if (busy && (irq_pending || warm_reset_req)) begin
                flash_command_status[FPUS_BIT_OI] <= 1'b1;
            end
            if (start_req && page_secured) begin
                flash_command_status[FPUS_BIT_SV] <= 1'b1;
            end
            if (busy && hv_err) begin
                flash_command_status[FPUS_BIT_HVE] <= 1'b1;
            end
            // interrupt or brownout in the cycle; a start blocked by brownout reports too
            if ((busy && (irq_pending || brownout)) || (start_req && brownout)) begin
                flash_command_status[FPUS_BIT_HVA] <= 1'b1;
            end
        end
    end

    // Low address register: software load or auto-increment
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_address_low <= FPUS_RESET_ADDR;
        end else if (sfr_wr && !busy && (sfr_addr == FPUS_ADDR_ADDR_LOW)) begin
            flash_address_low <= sfr_wdata;
        end else if (data_wr) begin
            // slot index wraps, page bits untouched
            flash_address_low <= {flash_address_low[7:SB],
                                  flash_address_low[SB-1:0] + SB'(1)};
        end
    end

    // High address register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_address_high <= FPUS_RESET_ADDR;
        end else if (sfr_wr && !busy && (sfr_addr == FPUS_ADDR_ADDR_HIGH)) begin
            flash_address_high <= sfr_wdata;
        end
    end

    // Update flags; a second load of one slot simply overwrites it
    always_ff @(posedge clk) begin
        if (!resetn || load_cmd) begin
            update_flag <= '0;
        end else if (data_wr) begin
            update_flag[flash_address_low[SB-1:0]] <= 1'b1;
        end
    end

    // byte storage, cleared by the load command
    fpus_page_buffer #(
        .DEPTH (FPUS_PAGE_BYTES),
        .AW    (SB)
    ) u_buffer (
        .clk     (clk),
        .resetn  (resetn),
        .clear   (load_cmd),
        .wr_en   (data_wr),
        .wr_addr (flash_address_low[SB-1:0]),
        .wr_data (sfr_wdata),
        .rd_addr (walk_idx[SB-1:0]),
        .rd_data (buf_rdata)
    );

    // Walk over all slots at the start of each phase; 65 cycles, well inside 2 ms
    always_ff @(posedge clk) begin
        if (!resetn || abort || !busy) begin
            walk_idx   <= '0;  // Parked at slot zero so the erase walk starts at once
            walk_valid <= 1'b0;
            walk_slot  <= '0;
        end else begin
            walk_valid <= (walk_idx != WALK_END);
            walk_slot  <= walk_idx[SB-1:0];
            if ((state != next_state) || (state == FPUS_ERASE && phase_done)) begin
                walk_idx <= '0;
            end else if (walk_idx != WALK_END) begin
                walk_idx <= walk_idx + (SB+1)'(1);
            end
        end
    end

    // Restart the walk on entry to the erase phase
    // (idle parks the index at slot zero, so entry needs no extra step)

    // page latched at start; sector is its upper bits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_page_addr <= '0;
            check_page      <= '0;
        end else begin
            check_page <= {flash_address_high, flash_address_low[7:SB]};
            if (go) begin
                flash_page_addr <= {flash_address_high, flash_address_low[7:SB]};
            end
        end
    end

    // strobes only for flagged slots, nothing else in the array
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_erase_strobe <= 1'b0;
            flash_prog_strobe  <= 1'b0;
            flash_byte_addr    <= '0;
            flash_wdata        <= 8'h00;
        end else begin
            flash_erase_strobe <= walk_valid && !abort && (state == FPUS_ERASE)
                                  && update_flag[walk_slot];
            flash_prog_strobe  <= walk_valid && !abort && (state == FPUS_PROGRAM)
                                  && update_flag[walk_slot];
            flash_byte_addr    <= walk_slot;
            flash_wdata        <= buf_rdata;
        end
    end

    // Read data one cycle after the strobe; write data register reads zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                FPUS_ADDR_CMD_STATUS: sfr_rdata <= {4'h0,
                                         flash_command_status[FPUS_STATUS_BITS-1:0]};
                FPUS_ADDR_ADDR_LOW:   sfr_rdata <= flash_address_low;
                FPUS_ADDR_ADDR_HIGH:  sfr_rdata <= flash_address_high;
                default:              sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Helper: cycles spent in the current cycle, for the duration check
    logic [31:0] busy_len;
    always_ff @(posedge clk) begin
        if (!resetn || !busy) begin
            busy_len <= 32'h0000_0000;
        end else begin
            busy_len <= busy_len + 32'h0000_0001;
        end
    end

    property p_load_clears;
        @(posedge clk) disable iff (!resetn) load_cmd |=> (update_flag == '0);
    endproperty
    a_load_clears: assert property (p_load_clears)
        else $error("load command left update flags set");

    property p_flag_set;
        @(posedge clk) disable iff (!resetn)
            data_wr |=> update_flag[$past(flash_address_low[SB-1:0])];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("data write did not set slot flag");

    property p_addr_incr;
        @(posedge clk) disable iff (!resetn)
            data_wr |=> (flash_address_low[SB-1:0] == $past(flash_address_low[SB-1:0]) + SB'(1))
                        && (flash_address_low[7:SB] == $past(flash_address_low[7:SB]));
    endproperty
    a_addr_incr: assert property (p_addr_incr)
        else $error("slot index increment or wrap wrong");

    property p_only_flagged;
        @(posedge clk) disable iff (!resetn)
            (flash_erase_strobe || flash_prog_strobe) |-> update_flag[flash_byte_addr];
    endproperty
    a_only_flagged: assert property (p_only_flagged)
        else $error("strobe for a byte without update flag");

    property p_stall;
        @(posedge clk) disable iff (!resetn) go |=> (cpu_stall && busy) [*2];
    endproperty
    a_stall: assert property (p_stall)
        else $error("processor not stalled after start");

    property p_duration;
        @(posedge clk) disable iff (!resetn)
            finish |-> (busy_len == 32'(2 * PHASE_CYCLES - 1));
    endproperty
    a_duration: assert property (p_duration)
        else $error("erase-program cycle length wrong");

    property p_irq_abort;
        @(posedge clk) disable iff (!resetn)
            (busy && irq_pending) |=> !busy && !cpu_stall
                && flash_command_status[FPUS_BIT_OI] && flash_command_status[FPUS_BIT_HVA];
    endproperty
    a_irq_abort: assert property (p_irq_abort)
        else $error("interrupt did not abort with flags");

    property p_cmd_clears;
        @(posedge clk) disable iff (!resetn)
            (cmd_wr && !start_req) |=> (flash_command_status == 8'h00);
    endproperty
    a_cmd_clears: assert property (p_cmd_clears)
        else $error("command write left status set");

    property p_bod_block;
        @(posedge clk) disable iff (!resetn)
            brownout |-> ##1 !flash_erase_strobe && !flash_prog_strobe;
    endproperty
    a_bod_block: assert property (p_bod_block)
        else $error("flash strobe while supply low");
endmodule : fpus_sequencer

// [tb/tb_flash_page_update_sequencer.sv]
// Self-checking bench for the flash page update sequencer
`timescale 1ns/1ps
module tb_flash_page_update_sequencer;
    import fpus_pkg::*;
    localparam int P = 200;                  // Short phase keeps the run brief
    logic       clk = 1'b0;                  // 200 MHz system clock
    logic       resetn = 1'b0;               // Held low for 12 cycles
    logic [7:0] sfr_addr = 8'h00;            // Register address
    logic [7:0] sfr_wdata = 8'h00;           // Register write data
    logic       sfr_wr = 1'b0;               // Write strobe
    logic       sfr_rd = 1'b0;               // Read strobe
    logic       irq_pending = 1'b0;          // Interrupt request
    logic       warm_reset_req = 1'b0;       // Reset-controller abort
    logic       page_secured = 1'b0;         // Target page secured
    logic       flash_brownout_detect = 1'b0; // Supply low monitor
    logic       hv_fault = 1'b0;             // Generator fault monitor
    logic [7:0] sfr_rdata, flash_wdata, r, page_hi, low;
    logic       cpu_stall, flash_erase_strobe, flash_prog_strobe;
    logic [9:0] check_page, flash_page_addr;
    logic [5:0] flash_byte_addr;
    logic [7:0] exp_data [64];               // Expected buffer bytes
    logic       exp_flag [64];               // Expected update flags
    // Status expected per abort event: none, irq, warm reset, brownout, fault
    logic [7:0] exp_st [5] = '{8'h00, 8'h09, 8'h01, 8'h08, 8'h04};
    int         num_errors = 0, n_checks = 0, n_erase = 0, n_prog = 0;

    always #2.5 clk = ~clk;

    fpus_sequencer #(.PHASE_CYCLES(P)) dut (
        .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .irq_pending(irq_pending), .warm_reset_req(warm_reset_req),
        .page_secured(page_secured), .cpu_stall(cpu_stall),
        .flash_brownout_detect(flash_brownout_detect), .hv_fault(hv_fault),
        .check_page(check_page), .flash_page_addr(flash_page_addr),
        .flash_byte_addr(flash_byte_addr), .flash_wdata(flash_wdata),
        .flash_erase_strobe(flash_erase_strobe), .flash_prog_strobe(flash_prog_strobe));

    // Closing report, also reached when a bounded wait runs out
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One-cycle register write, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1 sfr_wr = 1'b0;
        // Idle edge so back-to-back writes never re-raise the strobe in one step
        @(posedge clk);
        #1;
    endtask : wr

    // Read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        @(posedge clk);
        #1 r = sfr_rdata;
    endtask : rd

    function automatic int count_flags();
        int c = 0;
        foreach (exp_flag[i]) c += int'(exp_flag[i]);
        return c;
    endfunction : count_flags

    // clear, then n distinct slots of one page, wrapping
    task automatic load_page(input int n);
        logic [5:0] s;
        logic [7:0] d;
        wr(FPUS_ADDR_CMD_STATUS, FPUS_CMD_LOAD);
        foreach (exp_flag[i]) exp_flag[i] = 1'b0;
        wr(FPUS_ADDR_ADDR_HIGH, page_hi);
        wr(FPUS_ADDR_ADDR_LOW, low);
        s = low[5:0];
        repeat (n) begin
            d = 8'($urandom);
            wr(FPUS_ADDR_WRITE_DATA, d);
            exp_data[s] = d;
            exp_flag[s] = 1'b1;
            s = s + 6'd1;
        end
        rd(FPUS_ADDR_ADDR_LOW);
        chk(r, {low[7:6], s}, "address low after load");
        chk(check_page, {page_hi, low[7:6]}, "page offered for security check");
    endtask : load_page

    // Start erase-program; ev picks an abort event raised in the program phase
    task automatic run_cycle(input int ev);
        int n;
        n_erase = 0;
        n_prog = 0;
        wr(FPUS_ADDR_CMD_STATUS, FPUS_CMD_ERASE_PROG);
        chk(cpu_stall, 1, "stall after start");
        chk(flash_page_addr, {page_hi, low[7:6]}, "page select");
        n = 1;
        while (cpu_stall === 1'b1 && n < 3 * P) begin
            if (n == P + 7) {hv_fault, flash_brownout_detect, warm_reset_req, irq_pending} =
                4'((1 << ev) >> 1);
            @(posedge clk);
            #1 n++;
        end
        if (n >= 3 * P) begin
            num_errors++;
            print_verdict();
        end
        {hv_fault, flash_brownout_detect, warm_reset_req, irq_pending} = 4'h0;
        if (ev == 0) begin
            chk(n, 2 * P, "stall length");
            chk(n_erase, count_flags(), "erase strobes");
            chk(n_prog, count_flags(), "program strobes");
        end else chk(n <= P + 13, 1, "abort latency");
        repeat (4) @(posedge clk);
        #1 rd(FPUS_ADDR_CMD_STATUS);
        chk(r, exp_st[ev], "status after cycle");
        $display("test cycle event %0d done", ev);
    endtask : run_cycle

    // Only flagged slots may be programmed, with their loaded bytes
    always @(posedge clk) begin
        if (flash_erase_strobe === 1'b1) n_erase++;
        if (flash_prog_strobe === 1'b1) begin
            n_prog++;
            chk(flash_wdata, exp_data[flash_byte_addr], "programmed byte");
            chk(exp_flag[flash_byte_addr], 1, "programmed slot flagged");
        end
    end

    initial begin
        void'($urandom(32'hf60b83e5));
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        foreach (exp_st[i]) begin
            rd(8'he4 + 8'(i));
            chk(r, 8'h00, "reset value or unmapped read");
        end
        $display("test reset values done");
        page_hi = 8'($urandom);
        low = 8'($urandom) | 8'h3e;
        load_page(5);
        run_cycle(0);
        for (int ev = 1; ev < 5; ev++) begin
            low = 8'($urandom);
            load_page(1 + $urandom_range(63));
            run_cycle(ev);
        end
        wr(FPUS_ADDR_CMD_STATUS, 8'h5a);
        rd(FPUS_ADDR_CMD_STATUS);
        chk(r, 8'h00, "command write clears status");
        for (int k = 0; k < 2; k++) begin
            {flash_brownout_detect, page_secured} = 2'(1 << k);
            repeat (4) @(posedge clk);
            #1 wr(FPUS_ADDR_CMD_STATUS, FPUS_CMD_ERASE_PROG);
            @(posedge clk);
            #1 chk(cpu_stall, 0, "start refused");
            rd(FPUS_ADDR_CMD_STATUS);
            chk(r, (k == 0) ? 8'h02 : 8'h08, "refused start status");
            {flash_brownout_detect, page_secured} = 2'b00;
        end
        $display("test refused starts done");
        print_verdict();
    end
endmodule : tb_flash_page_update_sequencer
